// *** bench/cmbe_exec_checker.sv ***
`timescale 1ns/1ns
module cmbe_exec_checker
  import cmbe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire cmbe_op_t instr_op,
  input wire logic [4:0] instr_rd,
  input wire logic [2:0] instr_bit,
  input wire logic [11:0] instr_offset,
  input wire logic [15:0] instr_target,
  input wire logic [4:0] io_addr,
  input wire logic [7:0] io_rdata,
  input wire logic [15:0] stack_top,
  input wire logic stack_push,
  input wire logic [15:0] stack_push_data,
  input wire logic stack_pop,
  input wire logic flag_wr_en,
  input wire logic [15:0] pc,
  input wire logic [7:0] flag_register
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic keep;
  logic [15:0] k;
  assign acc = instr_valid && instr_ready;
  assign k = {{4{instr_offset[11]}}, instr_offset};
  // Ops that must leave every flag alone
  assign keep = (instr_op >= op_relative_jump && instr_op <= op_compare_skip_equal)
    || instr_op >= op_skip_reg_bit_clear;

  chk_prod_two_cycles:
  assert property (acc && instr_op >= op_product_unsigned
    && instr_op <= op_fractional_product_mixed |=> !instr_ready ##1 instr_ready)
    else $error("multiply did not take two cycles");
  chk_rel_jump:
  assert property (acc && instr_op == op_relative_jump |=> !instr_ready ##1
    (instr_ready && pc == $past(pc, 2) + $past(k, 2) + 16'h0001))
    else $error("relative jump target or timing wrong");
  chk_abs_jump:
  assert property (acc && instr_op == op_absolute_jump |=> !instr_ready [*2] ##1
    (instr_ready && pc == $past(instr_target, 3)))
    else $error("absolute jump target or timing wrong");
  chk_call_push:
  assert property (acc && instr_op == op_relative_invoke |=> !instr_ready ##1
    (stack_push && !instr_ready && stack_push_data == $past(pc, 2) + 16'h0001
    && pc == $past(pc, 2) + $past(k, 2) + 16'h0001) ##1 instr_ready)
    else $error("relative call push or target wrong");
  chk_abs_call:
  assert property (acc && instr_op == op_absolute_invoke |=> !instr_ready [*3] ##1 instr_ready)
    else $error("absolute call did not take four cycles");
  chk_return_pop:
  assert property (acc && (instr_op == op_subroutine_return
    || instr_op == op_interrupt_return) |=> !instr_ready ##1
    (stack_pop && !instr_ready && pc == $past(stack_top)) ##1 !instr_ready ##1 instr_ready)
    else $error("return pop, target or timing wrong");
  chk_io_skip:
  assert property (acc && (instr_op == op_skip_io_bit_set || instr_op == op_skip_io_bit_clear)
    |=> io_addr == $past(instr_rd)
    && instr_ready == (io_rdata[$past(instr_bit)] != ($past(instr_op) == op_skip_io_bit_set)))
    else $error("io skip address or decision wrong");
  chk_branch_shape:
  assert property (acc && instr_op >= op_branch_status_bit_set |=>
    (instr_ready ##1 pc == $past(pc, 2) + 16'h0001) or
    (!instr_ready ##1 (instr_ready && pc == $past(pc, 2) + $past(k, 2) + 16'h0001)))
    else $error("branch timing or target wrong");
  chk_flags_kept:
  assert property ($past(acc && keep) && !flag_wr_en |=> $stable(flag_register))
    else $error("control op changed a flag");
endmodule : cmbe_exec_checker

bind cmbe_exec cmbe_exec_checker u_chk (.ref_clk, .rst_n, .instr_valid, .instr_ready,
  .instr_op, .instr_rd, .instr_bit, .instr_offset, .instr_target, .io_addr, .io_rdata,
  .stack_top, .stack_push, .stack_push_data, .stack_pop, .flag_wr_en, .pc, .flag_register);

// *** bench/test_cmbe_exec.sv ***
`timescale 1ns/1ns
module test_cmbe_exec;
  import cmbe_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic instr_ready;
  cmbe_op_t instr_op = op_none;
  logic [4:0] instr_rd = 5'h00;
  logic [4:0] instr_rr = 5'h00;
  logic [2:0] instr_bit = 3'h0;
  logic [11:0] instr_offset = 12'h000;
  logic [7:0] instr_imm = 8'h00;
  logic [15:0] instr_target = 16'h0000;
  logic instr_next_two_word = 1'b0;
  logic [4:0] io_addr;
  logic [7:0] io_rdata = 8'h04;
  logic [15:0] stack_top = 16'h0000;
  logic stack_push;
  logic stack_pop;
  logic [15:0] stack_push_data;
  logic reg_wr_en = 1'b0;
  logic [4:0] reg_wr_addr = 5'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic flag_wr_en = 1'b0;
  logic [7:0] flag_wr_data = 8'h00;
  logic [15:0] pc;
  logic [7:0] flag_register;
  logic [15:0] push_d = 16'h0000;
  int push_n = 0;
  int pop_n = 0;
  int error_cnt = 0;
  int total_checks = 0;

  cmbe_exec dut (.ref_clk, .rst_n, .instr_valid, .instr_ready, .instr_op, .instr_rd,
    .instr_rr, .instr_bit, .instr_offset, .instr_imm, .instr_target, .instr_next_two_word,
    .io_addr, .io_rdata, .stack_top, .stack_push, .stack_push_data, .stack_pop,
    .reg_wr_en, .reg_wr_addr, .reg_wr_data, .flag_wr_en, .flag_wr_data, .pc,
    .flag_register);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (stack_push === 1'b1) begin
      push_d <= stack_push_data;
      push_n <= push_n + 1;
    end
    if (stack_pop === 1'b1) begin
      pop_n <= pop_n + 1;
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_wr_addr = a;
    reg_wr_data = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic fl(input logic [7:0] v);
    @(negedge ref_clk);
    flag_wr_en = 1'b1;
    flag_wr_data = v;
    @(negedge ref_clk);
    flag_wr_en = 1'b0;
  endtask : fl

  // Returns once the offered instruction has finished
  task automatic run(input cmbe_op_t op, input logic [4:0] rd = 5'h00,
      input logic [4:0] rr = 5'h00, input logic [2:0] b = 3'h0,
      input logic [11:0] off = 12'h000, input logic two = 1'b0);
    int n;
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr_op = op;
    instr_rd = rd;
    instr_rr = rr;
    instr_bit = b;
    instr_offset = off;
    instr_next_two_word = two;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    @(negedge ref_clk);
    n = 0;
    while (instr_ready !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 8) begin
      error_cnt++;
      $display("[ERR] %0t ready stuck low", $time);
    end
  endtask : run

  task automatic t_reset();
    cmp(pc, 16'h0000);
    cmp({8'h00, flag_register}, 16'h0000);
  endtask : t_reset

  task automatic t_test();
    wr(5'h05, 8'h80);
    run(op_test_sign_zero, 5'h05);
    cmp({12'h000, flag_register[3:0]}, 16'h0004);
    wr(5'h06, 8'h00);
    run(op_test_sign_zero, 5'h06);
    cmp({12'h000, flag_register[3:0]}, 16'h0002);
  endtask : t_test

  task automatic t_prod();
    cmbe_op_t ops[7] = '{op_product_unsigned, op_product_signed, op_product_mixed_sign,
      op_fractional_product_unsigned, op_fractional_product_signed,
      op_fractional_product_mixed, op_product_unsigned};
    logic [7:0] a[7] = '{8'hFF, 8'hFF, 8'hFF, 8'h80, 8'h80, 8'h80, 8'h00};
    logic [15:0] p[7] = '{16'hFE01, 16'h0001, 16'hFF01, 16'h8000, 16'h8000, 16'h8000, 16'h0000};
    logic c[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 7; i++) begin
      wr(5'h10, a[i]);
      wr(5'h11, a[i]);
      run(ops[i], 5'h10, 5'h11);
      cmp({14'h0000, flag_register[1:0]}, {14'h0000, p[i] == 16'h0000, c[i]});
      instr_imm = p[i][7:0];
      run(op_compare_immediate);
      cmp({15'h0000, flag_register[1]}, 16'h0001);
      instr_imm = p[i][15:8];
      run(op_compare_immediate, 5'h01);
      cmp({15'h0000, flag_register[1]}, 16'h0001);
    end
  endtask : t_prod

  task automatic t_cmp();
    run(op_compare, 5'h05, 5'h05);
    cmp({8'h00, flag_register & 8'h2F}, 16'h0002);
    instr_imm = 8'h01;
    run(op_compare_immediate, 5'h06);
    cmp({8'h00, flag_register & 8'h2F}, 16'h0025);
    run(op_compare_with_borrow, 5'h06, 5'h05);
    cmp({8'h00, flag_register & 8'h2F}, 16'h0021);
  endtask : t_cmp

  task automatic t_jump_call();
    instr_target = 16'h0100;
    run(op_absolute_jump);
    cmp(pc, 16'h0100);
    run(op_relative_jump, 5'h00, 5'h00, 3'h0, 12'hFFB);
    cmp(pc, 16'h00FC);
    wr(5'h1E, 8'h34);
    wr(5'h1F, 8'h12);
    run(op_indirect_jump);
    cmp(pc, 16'h1234);
    run(op_relative_invoke, 5'h00, 5'h00, 3'h0, 12'h010);
    cmp(pc, 16'h1245);
    cmp(push_d, 16'h1235);
    instr_target = 16'h2000;
    run(op_absolute_invoke);
    cmp(pc, 16'h2000);
    run(op_indirect_invoke);
    cmp(pc, 16'h1234);
    cmp(push_d, 16'h2001);
    stack_top = 16'h0ABC;
    run(op_subroutine_return);
    cmp(pc, 16'h0ABC);
    stack_top = 16'h0DEF;
    run(op_interrupt_return);
    cmp(pc, 16'h0DEF);
    cmp(16'(push_n * 16 + pop_n), 16'h0032);
  endtask : t_jump_call

  task automatic t_skip();
    cmbe_op_t ops[8] = '{op_compare_skip_equal, op_compare_skip_equal, op_skip_reg_bit_clear,
      op_skip_reg_bit_set, op_skip_reg_bit_set, op_skip_io_bit_set, op_skip_io_bit_clear,
      op_skip_io_bit_clear};
    logic [4:0] rr[8] = '{5'h11, 5'h05, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h10};
    logic [2:0] b[8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3};
    logic two[8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [15:0] d[8] = '{16'h3, 16'h1, 16'h2, 16'h1, 16'h3, 16'h2, 16'h1, 16'h3};
    logic [15:0] p0;
    wr(5'h10, 8'h5A);
    wr(5'h11, 8'h5A);
    fl(8'hA5);
    for (int i = 0; i < 8; i++) begin
      p0 = pc;
      run(ops[i], 5'h10, rr[i], b[i], 12'h000, two[i]);
      cmp(pc, p0 + d[i]);
    end
    cmp({8'h00, flag_register}, 16'h00A5);
  endtask : t_skip

  function automatic logic tk(input cmbe_op_t o, input logic [7:0] f, input logic [2:0] s);
    case (o)
      op_branch_status_bit_set: return f[s];
      op_branch_status_bit_clear: return !f[s];
      op_branch_equal: return f[1];
      op_branch_not_equal: return !f[1];
      op_branch_carry_set, op_branch_lower: return f[0];
      op_branch_carry_clear, op_branch_same_higher: return !f[0];
      op_branch_minus: return f[2];
      op_branch_plus: return !f[2];
      op_branch_signed_ge: return !(f[2] ^ f[3]);
      op_branch_signed_less: return f[2] ^ f[3];
      op_branch_half_set: return f[5];
      op_branch_half_clear: return !f[5];
      op_branch_transfer_set: return f[6];
      op_branch_transfer_clear: return !f[6];
      op_branch_overflow_set: return f[3];
      default: return !f[3];
    endcase
  endfunction : tk

  task automatic t_branch();
    logic [7:0] fp[3] = '{8'h00, 8'hFF, 8'h04};
    logic [15:0] off;
    logic t;
    logic [15:0] p0;
    cmbe_op_t o;
    for (int i = op_branch_status_bit_set; i <= op_branch_overflow_clear; i++) begin
      for (int j = 0; j < 3; j++) begin
        o = cmbe_op_t'(i);
        off = (j == 1) ? 16'hFFFE : 16'h0005;
        fl(fp[j]);
        p0 = pc;
        run(o, 5'h00, 5'h00, 3'(j + 1), off[11:0]);
        t = tk(o, fp[j], 3'(j + 1));
        cmp(pc, p0 + 16'h1 + (t ? off : 16'h0));
        cmp({8'h00, flag_register}, {8'h00, fp[j]});
      end
    end
  endtask : t_branch

  initial begin
    #100000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_test();
    t_prod();
    t_cmp();
    t_jump_call();
    t_skip();
    t_branch();
    results();
  end
endmodule : test_cmbe_exec

// *** design/cmbe_exec.sv ***
// Notes on behaviour
// - Register test updates zero, negative, overflow flags from Rd; one cycle.
// - Plain multiplies put 16-bit product in R1:R0, set Z and C; two cycles.
// - Fractional multiplies shift product left once before R1:R0; Z, C; two cycles.
// - Relative and indirect jumps take two cycles, absolute three; no flags.
// - Relative/indirect calls three cycles, absolute call four, returns four.
// - Compare-skip skips next instruction when registers equal; flags untouched.
// - Compares subtract without storing, updating Z, N, V, C and H.
// - Register bit skips test a general register bit, clear or set form.
// - I/O bit skips test an I/O register bit, clear or set form.
// - Generic branches test flag bit s, set or clear; one or two cycles.
// - Equality, carry and sign branches test Z, C and N respectively.
// - Signed ge and less branches use N xor V being 0 or 1.
// - Half-carry and transfer-bit branches in both set and clear forms.
// - Overflow branches test V set or clear, target PC plus offset plus one.
`timescale 1ns/1ns
`include "cmbe_map.svh"

module cmbe_exec
  import cmbe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire cmbe_op_t instr_op,
  input wire logic [4:0] instr_rd,
  input wire logic [4:0] instr_rr,
  input wire logic [2:0] instr_bit,
  input wire logic [11:0] instr_offset,
  input wire logic [7:0] instr_imm,
  input wire logic [15:0] instr_target,
  input wire logic instr_next_two_word,
  output logic [4:0] io_addr,
  input wire logic [7:0] io_rdata,
  input wire logic [15:0] stack_top,
  output logic stack_push,
  output logic [15:0] stack_push_data,
  output logic stack_pop,
  input wire logic reg_wr_en,
  input wire logic [4:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic flag_wr_en,
  input wire logic [7:0] flag_wr_data,
  output logic [15:0] pc,
  output logic [7:0] flag_register
);

  // Extra stall cycles after the execute cycle
  function automatic logic [1:0] cmbe_extra(input logic [2:0] cyc);
    logic [2:0] d;
    d = cyc - 3'h1;
    return d[1:0];
  endfunction : cmbe_extra

  function automatic logic [15:0] cmbe_mult(input logic [7:0] a, input logic [7:0] b,
                                            input logic sa, input logic sb);
    logic [15:0] ea;
    logic [15:0] eb;
    logic [31:0] p;
    ea = {{8{sa & a[7]}}, a};
    eb = {{8{sb & b[7]}}, b};
    p = {16'h0000, ea} * {16'h0000, eb};
    return p[15:0];
  endfunction : cmbe_mult

  // Returns {H, V, N, Z, C} of d - s - cin
  function automatic logic [4:0] cmbe_sub_flags(input logic [7:0] d, input logic [7:0] s,
                                                input logic cin, input logic zchain,
                                                input logic zold);
    logic [7:0] r;
    logic h;
    logic v;
    logic c;
    logic z;
    r = d - s - {7'h00, cin};
    h = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
    v = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
    c = (~d[7] & s[7]) | (s[7] & r[7]) | (r[7] & ~d[7]);
    z = (r == `CMBE_BYTE_ZERO) & (~zchain | zold);
    return {h, v, r[7], z, c};
  endfunction : cmbe_sub_flags

  logic accept;
  logic [4:0] rd_addr_a;
  logic [4:0] rd_addr_b;
  logic [7:0] opa;
  logic [7:0] opb;
  logic pair_en;
  logic [15:0] pair_data;
  logic [1:0] extra;

  logic ex_valid_r, ex_valid_nxt;
  cmbe_op_t ex_op_r, ex_op_nxt;
  logic [2:0] ex_bit_r, ex_bit_nxt;
  logic [11:0] ex_off_r, ex_off_nxt;
  logic [7:0] ex_imm_r, ex_imm_nxt;
  logic [15:0] ex_target_r, ex_target_nxt;
  logic ex_two_r, ex_two_nxt;
  logic [4:0] io_addr_r, io_addr_nxt;
  logic [1:0] wait_r, wait_nxt;

  logic [15:0] pc_r, pc_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic push_r, push_nxt;
  logic [15:0] push_data_r, push_data_nxt;
  logic pop_r, pop_nxt;

  // A new instruction is refused while an earlier one still owes cycles
  assign instr_ready = (wait_r == 2'h0) && !(ex_valid_r && (extra != 2'h0));
  assign accept = instr_valid && instr_ready;

  // Indirect forms read the pointer pair through the two operand ports
  always_comb begin
    rd_addr_a = instr_rd;
    rd_addr_b = instr_rr;
    if (instr_op == op_indirect_jump || instr_op == op_indirect_invoke) begin
      rd_addr_a = `CMBE_REG_PTR_LO;
      rd_addr_b = `CMBE_REG_PTR_HI;
    end
  end

  cmbe_regfile u_regfile (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rd_en(accept),
    .rd_addr_a(rd_addr_a),
    .rd_addr_b(rd_addr_b),
    .rd_data_a(opa),
    .rd_data_b(opb),
    .wr_en(reg_wr_en),
    .wr_addr(reg_wr_addr),
    .wr_data(reg_wr_data),
    .pair_en(pair_en),
    .pair_data(pair_data)
  );

  // Issue stage
  always_comb begin
    ex_valid_nxt = accept;
    ex_op_nxt = ex_op_r;
    ex_bit_nxt = ex_bit_r;
    ex_off_nxt = ex_off_r;
    ex_imm_nxt = ex_imm_r;
    ex_target_nxt = ex_target_r;
    ex_two_nxt = ex_two_r;
    io_addr_nxt = io_addr_r;
    wait_nxt = wait_r;
    if (accept) begin
      ex_op_nxt = instr_op;
      ex_bit_nxt = instr_bit;
      ex_off_nxt = instr_offset;
      ex_imm_nxt = instr_imm;
      ex_target_nxt = instr_target;
      ex_two_nxt = instr_next_two_word;
      io_addr_nxt = instr_rd;
    end
    if (wait_r != 2'h0) begin
      wait_nxt = wait_r - 2'h1;
    end else if (ex_valid_r && extra != 2'h0) begin
      wait_nxt = extra - 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ex_valid_r <= 1'b0;
      ex_op_r <= op_none;
      ex_bit_r <= 3'h0;
      ex_off_r <= 12'h000;
      ex_imm_r <= `CMBE_BYTE_ZERO;
      ex_target_r <= `CMBE_PC_RST;
      ex_two_r <= 1'b0;
      io_addr_r <= 5'h00;
      wait_r <= 2'h0;
    end else begin
      ex_valid_r <= ex_valid_nxt;
      ex_op_r <= ex_op_nxt;
      ex_bit_r <= ex_bit_nxt;
      ex_off_r <= ex_off_nxt;
      ex_imm_r <= ex_imm_nxt;
      ex_target_r <= ex_target_nxt;
      ex_two_r <= ex_two_nxt;
      io_addr_r <= io_addr_nxt;
      wait_r <= wait_nxt;
    end
  end

  // Execute stage
  always_comb begin
    logic [15:0] step;
    logic [15:0] rel;
    logic [15:0] prod;
    logic [4:0] cf;
    logic is_branch;
    logic is_skip;
    logic cond;
    step = pc_r + `CMBE_STEP_ONE;
    rel = pc_r + {{4{ex_off_r[11]}}, ex_off_r} + `CMBE_STEP_ONE;
    prod = 16'h0000;
    cf = 5'h00;
    is_branch = 1'b0;
    is_skip = 1'b0;
    cond = 1'b0;
    extra = 2'h0;
    pair_en = 1'b0;
    pair_data = 16'h0000;
    pc_nxt = pc_r;
    flags_nxt = flag_wr_en ? flag_wr_data : flags_r;
    push_nxt = 1'b0;
    push_data_nxt = push_data_r;
    pop_nxt = 1'b0;
    if (ex_valid_r) begin
      pc_nxt = step;
      unique case (ex_op_r)
        op_none: begin
          pc_nxt = pc_r;
        end
        op_test_sign_zero: begin
          flags_nxt[`CMBE_FLAG_Z] = (opa & opa) == `CMBE_BYTE_ZERO;
          flags_nxt[`CMBE_FLAG_N] = opa[7];
          flags_nxt[`CMBE_FLAG_V] = 1'b0;
          extra = cmbe_extra(`CMBE_CYC_TEST);
        end
        op_product_unsigned, op_product_signed, op_product_mixed_sign,
        op_fractional_product_unsigned, op_fractional_product_signed,
        op_fractional_product_mixed: begin
          unique case (ex_op_r)
            op_product_signed, op_fractional_product_signed: begin
              prod = cmbe_mult(opa, opb, 1'b1, 1'b1);
            end
            op_product_mixed_sign, op_fractional_product_mixed: begin
              prod = cmbe_mult(opa, opb, 1'b1, 1'b0);
            end
            default: begin
              prod = cmbe_mult(opa, opb, 1'b0, 1'b0);
            end
          endcase
          // Carry is the product's top bit before any shift
          flags_nxt[`CMBE_FLAG_C] = prod[15];
          if (ex_op_r == op_fractional_product_unsigned ||
              ex_op_r == op_fractional_product_signed ||
              ex_op_r == op_fractional_product_mixed) begin
            pair_data = {prod[14:0], 1'b0};
          end else begin
            pair_data = prod;
          end
          pair_en = 1'b1;
          flags_nxt[`CMBE_FLAG_Z] = pair_data == 16'h0000;
          extra = cmbe_extra(`CMBE_CYC_PROD);
        end
        op_relative_jump: begin
          pc_nxt = rel;
          extra = cmbe_extra(`CMBE_CYC_JUMP_REL);
        end
        op_indirect_jump: begin
          pc_nxt = {opb, opa};
          extra = cmbe_extra(`CMBE_CYC_JUMP_IND);
        end
        op_absolute_jump: begin
          pc_nxt = ex_target_r;
          extra = cmbe_extra(`CMBE_CYC_JUMP_ABS);
        end
        op_relative_invoke: begin
          pc_nxt = rel;
          push_nxt = 1'b1;
          push_data_nxt = step;
          extra = cmbe_extra(`CMBE_CYC_CALL_REL);
        end
        op_indirect_invoke: begin
          pc_nxt = {opb, opa};
          push_nxt = 1'b1;
          push_data_nxt = step;
          extra = cmbe_extra(`CMBE_CYC_CALL_IND);
        end
        op_absolute_invoke: begin
          // Return lands after the two-word call itself
          pc_nxt = ex_target_r;
          push_nxt = 1'b1;
          push_data_nxt = pc_r + `CMBE_STEP_TWO;
          extra = cmbe_extra(`CMBE_CYC_CALL_ABS);
        end
        op_subroutine_return, op_interrupt_return: begin
          pc_nxt = stack_top;
          pop_nxt = 1'b1;
          extra = cmbe_extra(`CMBE_CYC_RETURN);
        end
        op_compare_skip_equal: begin
          is_skip = 1'b1;
          cond = opa == opb;
        end
        op_compare, op_compare_with_borrow, op_compare_immediate: begin
          if (ex_op_r == op_compare_immediate) begin
            cf = cmbe_sub_flags(opa, ex_imm_r, 1'b0, 1'b0, 1'b0);
          end else if (ex_op_r == op_compare_with_borrow) begin
            cf = cmbe_sub_flags(opa, opb, flags_r[`CMBE_FLAG_C], 1'b1,
                                flags_r[`CMBE_FLAG_Z]);
          end else begin
            cf = cmbe_sub_flags(opa, opb, 1'b0, 1'b0, 1'b0);
          end
          flags_nxt[`CMBE_FLAG_H] = cf[4];
          flags_nxt[`CMBE_FLAG_V] = cf[3];
          flags_nxt[`CMBE_FLAG_N] = cf[2];
          flags_nxt[`CMBE_FLAG_Z] = cf[1];
          flags_nxt[`CMBE_FLAG_C] = cf[0];
          extra = cmbe_extra(`CMBE_CYC_COMPARE);
        end
        op_skip_reg_bit_clear, op_skip_reg_bit_set: begin
          is_skip = 1'b1;
          cond = opa[ex_bit_r] == (ex_op_r == op_skip_reg_bit_set);
        end
        op_skip_io_bit_clear, op_skip_io_bit_set: begin
          is_skip = 1'b1;
          cond = io_rdata[ex_bit_r] == (ex_op_r == op_skip_io_bit_set);
        end
        op_branch_status_bit_set: begin
          is_branch = 1'b1;
          cond = flags_r[ex_bit_r];
        end
        op_branch_status_bit_clear: begin
          is_branch = 1'b1;
          cond = ~flags_r[ex_bit_r];
        end
        op_branch_equal, op_branch_not_equal: begin
          is_branch = 1'b1;
          cond = flags_r[`CMBE_FLAG_Z] == (ex_op_r == op_branch_equal);
        end
        op_branch_carry_set, op_branch_lower: begin
          is_branch = 1'b1;
          cond = flags_r[`CMBE_FLAG_C];
        end
        op_branch_carry_clear, op_branch_same_higher: begin
          is_branch = 1'b1;
          cond = ~flags_r[`CMBE_FLAG_C];
        end
        op_branch_minus, op_branch_plus: begin
          is_branch = 1'b1;
          cond = flags_r[`CMBE_FLAG_N] == (ex_op_r == op_branch_minus);
        end
        op_branch_signed_ge, op_branch_signed_less: begin
          is_branch = 1'b1;
          cond = (flags_r[`CMBE_FLAG_N] ^ flags_r[`CMBE_FLAG_V]) ==
                 (ex_op_r == op_branch_signed_less);
        end
        op_branch_half_set, op_branch_half_clear: begin
          is_branch = 1'b1;
          cond = flags_r[`CMBE_FLAG_H] == (ex_op_r == op_branch_half_set);
        end
        op_branch_transfer_set, op_branch_transfer_clear: begin
          is_branch = 1'b1;
          cond = flags_r[`CMBE_FLAG_T] == (ex_op_r == op_branch_transfer_set);
        end
        op_branch_overflow_set, op_branch_overflow_clear: begin
          is_branch = 1'b1;
          cond = flags_r[`CMBE_FLAG_V] == (ex_op_r == op_branch_overflow_set);
        end
      endcase
      if (is_branch) begin
        if (cond) begin
          pc_nxt = rel;
          extra = cmbe_extra(`CMBE_CYC_BR_TAKEN);
        end else begin
          extra = cmbe_extra(`CMBE_CYC_BR_NOT);
        end
      end
      if (is_skip) begin
        if (!cond) begin
          extra = cmbe_extra(`CMBE_CYC_NO_SKIP);
        end else if (ex_two_r) begin
          pc_nxt = pc_r + `CMBE_STEP_THREE;
          extra = cmbe_extra(`CMBE_CYC_SKIP_TWO);
        end else begin
          pc_nxt = pc_r + `CMBE_STEP_TWO;
          extra = cmbe_extra(`CMBE_CYC_SKIP_ONE);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= `CMBE_PC_RST;
      flags_r <= `CMBE_FLAGS_RST;
      push_r <= 1'b0;
      push_data_r <= `CMBE_PC_RST;
      pop_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      flags_r <= flags_nxt;
      push_r <= push_nxt;
      push_data_r <= push_data_nxt;
      pop_r <= pop_nxt;
    end
  end

  assign pc = pc_r;
  assign flag_register = flags_r;
  assign io_addr = io_addr_r;
  assign stack_push = push_r;
  assign stack_push_data = push_data_r;
  assign stack_pop = pop_r;

endmodule : cmbe_exec

// *** design/cmbe_map.svh ***
`ifndef CMBE_MAP_SVH
`define CMBE_MAP_SVH

// Reset values
`define CMBE_PC_RST 16'h0000
`define CMBE_FLAGS_RST 8'h00
`define CMBE_BYTE_ZERO 8'h00

// Flag register bit positions
`define CMBE_FLAG_C 0
`define CMBE_FLAG_Z 1
`define CMBE_FLAG_N 2
`define CMBE_FLAG_V 3
`define CMBE_FLAG_S 4
`define CMBE_FLAG_H 5
`define CMBE_FLAG_T 6
`define CMBE_FLAG_I 7

// Fixed registers
`define CMBE_REG_PROD_LO 5'h00
`define CMBE_REG_PROD_HI 5'h01
`define CMBE_REG_PTR_LO 5'h1E
`define CMBE_REG_PTR_HI 5'h1F

// Program counter steps
`define CMBE_STEP_ONE 16'h0001
`define CMBE_STEP_TWO 16'h0002
`define CMBE_STEP_THREE 16'h0003

// Cycle counts per instruction
`define CMBE_CYC_TEST 3'h1
`define CMBE_CYC_PROD 3'h2
`define CMBE_CYC_JUMP_REL 3'h2
`define CMBE_CYC_JUMP_IND 3'h2
`define CMBE_CYC_JUMP_ABS 3'h3
`define CMBE_CYC_CALL_REL 3'h3
`define CMBE_CYC_CALL_IND 3'h3
`define CMBE_CYC_CALL_ABS 3'h4
`define CMBE_CYC_RETURN 3'h4
`define CMBE_CYC_COMPARE 3'h1
`define CMBE_CYC_NO_SKIP 3'h1
`define CMBE_CYC_SKIP_ONE 3'h2
`define CMBE_CYC_SKIP_TWO 3'h3
`define CMBE_CYC_BR_NOT 3'h1
`define CMBE_CYC_BR_TAKEN 3'h2

`endif

// *** design/cmbe_pkg.sv ***
package cmbe_pkg;

  typedef enum logic [5:0] {
    op_none,
    op_test_sign_zero,
    op_product_unsigned,
    op_product_signed,
    op_product_mixed_sign,
    op_fractional_product_unsigned,
    op_fractional_product_signed,
    op_fractional_product_mixed,
    op_relative_jump,
    op_indirect_jump,
    op_absolute_jump,
    op_relative_invoke,
    op_indirect_invoke,
    op_absolute_invoke,
    op_subroutine_return,
    op_interrupt_return,
    op_compare_skip_equal,
    op_compare,
    op_compare_with_borrow,
    op_compare_immediate,
    op_skip_reg_bit_clear,
    op_skip_reg_bit_set,
    op_skip_io_bit_clear,
    op_skip_io_bit_set,
    op_branch_status_bit_set,
    op_branch_status_bit_clear,
    op_branch_equal,
    op_branch_not_equal,
    op_branch_carry_set,
    op_branch_carry_clear,
    op_branch_same_higher,
    op_branch_lower,
    op_branch_minus,
    op_branch_plus,
    op_branch_signed_ge,
    op_branch_signed_less,
    op_branch_half_set,
    op_branch_half_clear,
    op_branch_transfer_set,
    op_branch_transfer_clear,
    op_branch_overflow_set,
    op_branch_overflow_clear
  } cmbe_op_t;

endpackage : cmbe_pkg

// *** design/cmbe_regfile.sv ***
`timescale 1ns/1ns
`include "cmbe_map.svh"

module cmbe_regfile (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  output logic [7:0] rd_data_a,
  output logic [7:0] rd_data_b,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic pair_en,
  input wire logic [15:0] pair_data
);

  logic [7:0] mem [0:31];

  // Product pair write wins over the general port when both hit R1 or R0
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        mem[i] <= `CMBE_BYTE_ZERO;
      end
      rd_data_a <= `CMBE_BYTE_ZERO;
      rd_data_b <= `CMBE_BYTE_ZERO;
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      if (pair_en) begin
        mem[`CMBE_REG_PROD_LO] <= pair_data[7:0];
        mem[`CMBE_REG_PROD_HI] <= pair_data[15:8];
      end
      if (rd_en) begin
        rd_data_a <= mem[rd_addr_a];
        rd_data_b <= mem[rd_addr_b];
      end
    end
  end

endmodule : cmbe_regfile
